// >>> logic/oiofm_in_cond.sv
// One optional input port: synchroniser, polarity and press detector
`timescale 1ns/1ns
module oiofm_in_cond
  import oiofm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic i_active_high,
  output logic o_level,
  output logic o_press
);
  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic press_q;
  logic active;

  assign active = i_active_high ? sync2_q : ~sync2_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // Idle level of a pulled-up pin, so no false press follows reset
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      level_q <= 1'b0;
      press_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      level_q <= active;
      press_q <= active & ~level_q;
    end
  end

  assign o_level = level_q;
  assign o_press = press_q;
endmodule // oiofm_in_cond

// >>> logic/oiofm_mapper.sv
// Optional input/output function mapper with AXI4-Lite configuration
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module oiofm_mapper
  import oiofm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic [NPORT-1:0] i_opt_in,
  output logic [NPORT-1:0] o_opt_out,
  input wire logic i_trim_sol,
  input wire logic i_wiper_sol,
  input wire logic i_release_sol,
  input wire logic i_lift_sol,
  input wire logic i_reverse_sol,
  input wire logic i_machine_stopped,
  input wire logic i_needle_down,
  input wire logic i_const_dim_pattern,
  input wire logic i_back_pedal_press,
  output logic o_trim_magnet,
  output logic o_wiper_magnet,
  output logic o_release_magnet,
  output logic o_lift_magnet,
  output logic o_reverse_magnet,
  output logic o_half_stitch_input,
  output logic o_back_compensate_input,
  output logic o_once_end_cancel,
  output logic o_trim_switch_input,
  output logic o_presser_lift,
  output logic o_single_stitch_input,
  output logic o_start_end_reverse_cancel,
  output logic o_neutral_autolift,
  output logic o_fabric_border_sensor,
  output logic o_pedal_run_inhibit,
  output logic o_trim_inhibit,
  output logic o_low_speed_command,
  output logic o_high_speed_command,
  output logic o_needle_raise_input,
  output logic o_reverse_lift_input,
  output logic o_safety_input,
  output logic o_knife_sensor_input,
  output logic o_auto_reverse_toggle,
  output logic o_alt_lift_amount
);
  logic [IN_CODE_W-1:0] in_code_q [NPORT];
  logic [NPORT-1:0] in_pol_q;
  logic [OUT_CODE_W-1:0] out_code_q [NPORT];
  logic [NPORT-1:0] in_lvl;
  logic [NPORT-1:0] in_press;
  logic [31:0] lvl_hot [NPORT];
  logic [31:0] press_hot [NPORT];
  logic [15:0] out_hot [NPORT];
  logic [NPORT-1:0] lvl_t [32];
  logic [NPORT-1:0] press_t [32];
  logic [NPORT-1:0] use_t [16];
  logic [31:0] fn_lvl;
  logic [31:0] fn_press;
  logic [15:0] sol_used;
  logic [15:0] out_src;
  logic [NPORT-1:0] opt_out_q;

  // Per-port conditioning and code decode (ports 901..908, 911..918)
  genvar gi;
  genvar gc;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      oiofm_in_cond u_cond (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_opt_in[gi]),
        .i_active_high(in_pol_q[gi]),
        .o_level(in_lvl[gi]),
        .o_press(in_press[gi])
      );
      assign lvl_hot[gi] = in_lvl[gi] ? (32'h1 << in_code_q[gi]) : 32'h0;
      assign press_hot[gi] = in_press[gi] ? (32'h1 << in_code_q[gi]) : 32'h0;
      assign out_hot[gi] = 16'h1 << out_code_q[gi];
      for (gc = 0; gc < 32; gc++) begin : g_t
        assign lvl_t[gc][gi] = lvl_hot[gi][gc];
        assign press_t[gc][gi] = press_hot[gi][gc];
      end
      for (gc = 0; gc < 16; gc++) begin : g_u
        assign use_t[gc][gi] = out_hot[gi][gc];
      end
    end
    for (gc = 0; gc < 32; gc++) begin : g_fn
      // Code zero decodes but drives nothing
      assign fn_lvl[gc] = (gc != IN_NOP) && (|lvl_t[gc]);
      assign fn_press[gc] = (gc != IN_NOP) && (|press_t[gc]);
    end
    for (gc = 0; gc < 16; gc++) begin : g_use
      assign sol_used[gc] = |use_t[gc];
    end
  endgenerate

  // Toggled and armed modes
  logic once_q;
  logic se_cancel_q;
  logic autolift_q;
  logic auto_rev_q;
  logic alt_tog_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      once_q <= 1'b0;
      se_cancel_q <= 1'b0;
      autolift_q <= 1'b0;
      auto_rev_q <= 1'b0;
      alt_tog_q <= 1'b0;
    end else begin
      // Arming wins over consumption in the same cycle
      if (fn_press[IN_ONCE_CANCEL]) begin
        once_q <= 1'b1;
      end else if (i_back_pedal_press) begin
        once_q <= 1'b0;
      end
      se_cancel_q <= se_cancel_q ^ fn_press[IN_SE_CANCEL];
      autolift_q <= autolift_q ^ fn_press[IN_AUTOLIFT];
      auto_rev_q <= auto_rev_q ^ fn_press[IN_AUTO_REV];
      alt_tog_q <= alt_tog_q ^ fn_press[IN_ALT_TOGGLE];
    end
  end

  // Commands toward the sequencing core
  logic [18:0] cmd_d;
  logic [18:0] cmd_q;
  logic trim_eff;
  assign trim_eff = i_trim_sol & ~fn_lvl[IN_TRIM_INH];
  assign cmd_d[0] = fn_press[IN_HALF_STITCH];
  assign cmd_d[1] = fn_lvl[IN_BACK_COMP] & i_const_dim_pattern;
  assign cmd_d[2] = once_q;
  assign cmd_d[3] = fn_lvl[IN_TRIM_SW];
  assign cmd_d[4] = fn_lvl[IN_LIFT_SW];
  assign cmd_d[5] = fn_press[IN_ONE_STITCH];
  assign cmd_d[6] = se_cancel_q;
  assign cmd_d[7] = autolift_q;
  assign cmd_d[8] = fn_lvl[IN_EDGE];
  assign cmd_d[9] = fn_lvl[IN_PEDAL_INH];
  assign cmd_d[10] = fn_lvl[IN_TRIM_INH];
  assign cmd_d[11] = fn_lvl[IN_LOW_SPEED];
  assign cmd_d[12] = fn_lvl[IN_HIGH_SPEED];
  assign cmd_d[13] = fn_press[IN_RAISE] & i_needle_down;
  assign cmd_d[14] = fn_press[IN_REV_LIFT] & i_needle_down;
  assign cmd_d[15] = fn_lvl[IN_SAFETY];
  assign cmd_d[16] = fn_lvl[IN_KNIFE];
  assign cmd_d[17] = auto_rev_q;
  assign cmd_d[18] = alt_tog_q | fn_lvl[IN_ALT_KNEE];

  // Output port sources by function code
  assign out_src[0] = 1'b0;
  assign out_src[OUT_TRIM] = trim_eff;
  assign out_src[OUT_WIPER] = i_wiper_sol;
  assign out_src[OUT_RELEASE] = i_release_sol;
  assign out_src[OUT_LIFT] = i_lift_sol;
  assign out_src[OUT_REVERSE] = i_reverse_sol;
  assign out_src[OUT_ONCE_MON] = once_q;
  assign out_src[OUT_SE_MON] = se_cancel_q;
  assign out_src[OUT_AUTO_MON] = auto_rev_q;
  assign out_src[OUT_ALT] = cmd_q[18];
  assign out_src[OUT_STOPPED] = i_machine_stopped;
  assign out_src[15:11] = 5'h00;

  logic [4:0] mag_d;
  logic [4:0] mag_q;
  assign mag_d[0] = trim_eff & ~sol_used[OUT_TRIM];
  assign mag_d[1] = i_wiper_sol & ~sol_used[OUT_WIPER];
  assign mag_d[2] = i_release_sol & ~sol_used[OUT_RELEASE];
  assign mag_d[3] = i_lift_sol & ~sol_used[OUT_LIFT];
  assign mag_d[4] = i_reverse_sol & ~sol_used[OUT_REVERSE];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= '0;
      mag_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      mag_q <= mag_d;
    end
  end

  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_out
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          opt_out_q[gi] <= 1'b0;
        end else begin
          opt_out_q[gi] <= out_src[out_code_q[gi]];
        end
      end
    end
  endgenerate

  assign o_opt_out = opt_out_q;
  assign {o_reverse_magnet, o_lift_magnet, o_release_magnet, o_wiper_magnet, o_trim_magnet} = mag_q;
  assign o_half_stitch_input = cmd_q[0];
  assign o_back_compensate_input = cmd_q[1];
  assign o_once_end_cancel = cmd_q[2];
  assign o_trim_switch_input = cmd_q[3];
  assign o_presser_lift = cmd_q[4];
  assign o_single_stitch_input = cmd_q[5];
  assign o_start_end_reverse_cancel = cmd_q[6];
  assign o_neutral_autolift = cmd_q[7];
  assign o_fabric_border_sensor = cmd_q[8];
  assign o_pedal_run_inhibit = cmd_q[9];
  assign o_trim_inhibit = cmd_q[10];
  assign o_low_speed_command = cmd_q[11];
  assign o_high_speed_command = cmd_q[12];
  assign o_needle_raise_input = cmd_q[13];
  assign o_reverse_lift_input = cmd_q[14];
  assign o_safety_input = cmd_q[15];
  assign o_knife_sensor_input = cmd_q[16];
  assign o_auto_reverse_toggle = cmd_q[17];
  assign o_alt_lift_amount = cmd_q[18];

  // AXI4-Lite write path
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic wr_in_sel;
  logic wr_out_sel;
  logic wr_ok;
  logic [2:0] wr_idx;
  assign o_s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign o_s_axi_wready = ~w_have_q & ~bvalid_q;
  assign aw_take = i_s_axi_awvalid & o_s_axi_awready;
  assign w_take = i_s_axi_wvalid & o_s_axi_wready;
  assign do_write = aw_have_q & w_have_q;
  assign wr_idx = aw_addr_q[4:2];
  assign wr_in_sel = aw_addr_q[7:5] == SEL_IN_CFG;
  assign wr_out_sel = aw_addr_q[7:5] == SEL_OUT_CFG;
  assign wr_ok = wr_in_sel | wr_out_sel | (aw_addr_q[7:2] == ADDR_STATUS[7:2]);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_cfg
      logic we_in;
      logic we_out;
      assign we_in = do_write & wr_in_sel & (wr_idx == 3'(gi));
      assign we_out = do_write & wr_out_sel & (wr_idx == 3'(gi));
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          in_code_q[gi] <= IN_CODE_RESET;
          in_pol_q[gi] <= POL_RESET;
          out_code_q[gi] <= OUT_CODE_RESET;
        end else begin
          if (we_in && w_strb_q[0]) begin
            in_code_q[gi] <= w_data_q[IN_CODE_W-1:0];
          end
          if (we_in && w_strb_q[1]) begin
            in_pol_q[gi] <= w_data_q[POL_BIT];
          end
          if (we_out && w_strb_q[0]) begin
            out_code_q[gi] <= w_data_q[OUT_CODE_W-1:0];
          end
        end
      end
    end
  endgenerate

  // AXI4-Lite read path
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic [2:0] rd_idx;
  logic rd_in_sel;
  logic rd_out_sel;
  logic rd_stat_sel;
  logic [31:0] rd_data;
  logic [31:0] stat_word;
  assign o_s_axi_arready = ~rvalid_q;
  assign ar_take = i_s_axi_arvalid & ~rvalid_q;
  assign rd_idx = i_s_axi_araddr[4:2];
  assign rd_in_sel = i_s_axi_araddr[7:5] == SEL_IN_CFG;
  assign rd_out_sel = i_s_axi_araddr[7:5] == SEL_OUT_CFG;
  assign rd_stat_sel = i_s_axi_araddr[7:2] == ADDR_STATUS[7:2];
  assign stat_word = {19'h0, cmd_q[18], auto_rev_q, autolift_q, se_cancel_q, once_q, in_lvl};
  assign rd_data = rd_in_sel ? {23'h0, in_pol_q[rd_idx], 3'h0, in_code_q[rd_idx]} :
                   rd_out_sel ? {28'h0, out_code_q[rd_idx]} :
                   rd_stat_sel ? stat_word : 32'h0;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= (rd_in_sel | rd_out_sel | rd_stat_sel) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_half;
    fn_press[IN_HALF_STITCH] |=> o_half_stitch_input ##1 !o_half_stitch_input;
  endproperty
  a_half: assert property (p_half) else $error("half stitch pulse wrong");
  property p_back;
    o_back_compensate_input |-> $past(i_const_dim_pattern);
  endproperty
  a_back: assert property (p_back) else $error("back comp without pattern");
  property p_once;
    fn_press[IN_ONCE_CANCEL] |=> once_q ##1 o_once_end_cancel;
  endproperty
  a_once: assert property (p_once) else $error("once cancel not armed");
  property p_trim_sw;
    (in_code_q[0] == IN_CODE_W'(IN_TRIM_SW) && in_lvl[0]) |=> o_trim_switch_input;
  endproperty
  a_trim_sw: assert property (p_trim_sw) else $error("trim switch not passed");
  property p_se_tog;
    fn_press[IN_SE_CANCEL] |=> se_cancel_q != $past(se_cancel_q);
  endproperty
  a_se_tog: assert property (p_se_tog) else $error("start/end cancel not toggled");
  property p_raise;
    o_needle_raise_input |-> $past(i_needle_down) && $past(fn_press[IN_RAISE]);
  endproperty
  a_raise: assert property (p_raise) else $error("needle raise without down stop");
  property p_magnet;
    sol_used[OUT_TRIM] |=> !o_trim_magnet;
  endproperty
  a_magnet: assert property (p_magnet) else $error("trim magnet driven while mapped");
  property p_stopped;
    $past(out_code_q[0] == OUT_CODE_W'(OUT_STOPPED)) |-> o_opt_out[0] == $past(i_machine_stopped);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stop state output wrong");
  property p_safety;
    fn_lvl[IN_SAFETY] |=> o_safety_input;
  endproperty
  a_safety: assert property (p_safety) else $error("safety inhibit missing");
  property p_alt_knee;
    fn_lvl[IN_ALT_KNEE] |=> o_alt_lift_amount;
  endproperty
  a_alt_knee: assert property (p_alt_knee) else $error("alt amount not held");

  c_half: cover property (fn_press[IN_HALF_STITCH] ##1 o_half_stitch_input);
  c_alt_tog: cover property (fn_press[IN_ALT_TOGGLE] ##2 o_alt_lift_amount);
  c_raise: cover property (o_needle_raise_input);
  c_write: cover property (do_write && wr_in_sel);
endmodule // oiofm_mapper

// >>> logic/oiofm_pkg.sv
// Constants shared by the optional I/O function mapper
package oiofm_pkg;
  localparam int NPORT = 8;
  localparam int IN_CODE_W = 5;
  localparam int OUT_CODE_W = 4;
  localparam int ADDR_W = 8;
  localparam real CLOCK_PERIOD_NS = 20.0;
  // Input function codes
  localparam int IN_NOP = 0;
  localparam int IN_HALF_STITCH = 1;
  localparam int IN_BACK_COMP = 2;
  localparam int IN_ONCE_CANCEL = 3;
  localparam int IN_TRIM_SW = 4;
  localparam int IN_LIFT_SW = 5;
  localparam int IN_ONE_STITCH = 6;
  localparam int IN_SE_CANCEL = 7;
  localparam int IN_AUTOLIFT = 8;
  localparam int IN_EDGE = 9;
  localparam int IN_PEDAL_INH = 10;
  localparam int IN_TRIM_INH = 11;
  localparam int IN_LOW_SPEED = 12;
  localparam int IN_HIGH_SPEED = 13;
  localparam int IN_RAISE = 14;
  localparam int IN_REV_LIFT = 15;
  localparam int IN_SAFETY = 16;
  localparam int IN_KNIFE = 17;
  localparam int IN_AUTO_REV = 18;
  localparam int IN_ALT_TOGGLE = 19;
  localparam int IN_ALT_KNEE = 20;
  // Output function codes
  localparam int OUT_TRIM = 1;
  localparam int OUT_WIPER = 2;
  localparam int OUT_RELEASE = 3;
  localparam int OUT_LIFT = 4;
  localparam int OUT_REVERSE = 5;
  localparam int OUT_ONCE_MON = 6;
  localparam int OUT_SE_MON = 7;
  localparam int OUT_AUTO_MON = 8;
  localparam int OUT_ALT = 9;
  localparam int OUT_STOPPED = 10;
  // Register map and fields
  localparam logic [2:0] SEL_IN_CFG = 3'h0;
  localparam logic [2:0] SEL_OUT_CFG = 3'h1;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam int POL_BIT = 8;
  localparam logic [IN_CODE_W-1:0] IN_CODE_RESET = 5'h00;
  localparam logic [OUT_CODE_W-1:0] OUT_CODE_RESET = 4'h0;
  localparam logic POL_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> testbench/oiofm_mapper_bench.sv
// Self-checking bench for the optional I/O function mapper
`timescale 1ns/1ns
module oiofm_mapper_bench;
  import oiofm_pkg::*;
  logic clock, rst, awv, wv, bry, arv, rry, stopped, ndown, cdim, bpp;
  logic [7:0] awa, ara, closed;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [4:0] sol;
  wire awr, wr, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [7:0] pins, oo;
  wire [4:0] mag;
  wire [18:0] co;
  int error_cnt, num_checks;

  oiofm_switch_model oiofm_switch_model_inst (.i_clock(clock), .i_closed(closed), .o_pin(pins));
  oiofm_mapper oiofm_mapper_inst (.i_clock(clock), .i_rst(rst),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rd),
    .o_s_axi_rresp(rr), .i_opt_in(pins), .o_opt_out(oo), .i_trim_sol(sol[0]), .i_wiper_sol(sol[1]),
    .i_release_sol(sol[2]), .i_lift_sol(sol[3]), .i_reverse_sol(sol[4]), .i_machine_stopped(stopped),
    .i_needle_down(ndown), .i_const_dim_pattern(cdim), .i_back_pedal_press(bpp),
    .o_trim_magnet(mag[0]), .o_wiper_magnet(mag[1]), .o_release_magnet(mag[2]), .o_lift_magnet(mag[3]),
    .o_reverse_magnet(mag[4]), .o_half_stitch_input(co[0]), .o_back_compensate_input(co[1]),
    .o_once_end_cancel(co[2]), .o_trim_switch_input(co[3]), .o_presser_lift(co[4]),
    .o_single_stitch_input(co[5]), .o_start_end_reverse_cancel(co[6]), .o_neutral_autolift(co[7]),
    .o_fabric_border_sensor(co[8]), .o_pedal_run_inhibit(co[9]), .o_trim_inhibit(co[10]),
    .o_low_speed_command(co[11]), .o_high_speed_command(co[12]), .o_needle_raise_input(co[13]),
    .o_reverse_lift_input(co[14]), .o_safety_input(co[15]), .o_knife_sensor_input(co[16]),
    .o_auto_reverse_toggle(co[17]), .o_alt_lift_amount(co[18]));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clock);
      if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (wv && wr) begin dd = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clock); while (bv !== 1'b1);
    r = br;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clock); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clock); while (rv !== 1'b1);
    d = rd;
    r = rr;
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", RESP_OKAY, r);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", er, r);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Closes a switch for seven cycles and counts cycles with the watched output high
  task automatic press(input int p, input int idx, output int n);
    n = 0;
    closed[p] <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (i == 6) closed[p] <= 1'b0;
      if (co[idx] === 1'b1) n++;
    end
  endtask

  task automatic t_reset;
    rdchk("in_cfg0", 8'h00, 32'h0, RESP_OKAY);
    rdchk("out_cfg7", 8'h3C, 32'h0, RESP_OKAY);
    rdchk("unmapped", 8'h80, 32'h0, RESP_SLVERR);
    closed[0] <= 1'b1;
    cyc(8);
    chk("idle core", 32'h0, {oo, co});
    closed[0] <= 1'b0;
    $display("reset test done");
  endtask

  task automatic t_levels;
    int c[11] = '{IN_TRIM_SW, IN_LIFT_SW, IN_EDGE, IN_PEDAL_INH, IN_TRIM_INH, IN_LOW_SPEED,
                  IN_HIGH_SPEED, IN_SAFETY, IN_KNIFE, IN_ALT_KNEE, IN_BACK_COMP};
    int x[11] = '{3, 4, 8, 9, 10, 11, 12, 15, 16, 18, 1};
    cdim <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      cfg(8'h0C, c[k]);
      closed[3] <= 1'b1;
      cyc(8);
      chk("held level", 1, co[x[k]]);
      closed[3] <= 1'b0;
      cyc(8);
      chk("released level", 0, co[x[k]]);
    end
    cdim <= 1'b0;
    closed[3] <= 1'b1;
    cyc(8);
    chk("back comp no pattern", 0, co[1]);
    closed[3] <= 1'b0;
    cfg(8'h0C, 32'h100 | IN_TRIM_SW);
    cyc(8);
    chk("active high open", 1, co[3]);
    rdchk("in_cfg3", 8'h0C, 32'h104, RESP_OKAY);
    rdchk("in_cfg2", 8'h08, 32'h0, RESP_OKAY);
    cfg(8'h0C, 32'h0);
    $display("level test done");
  endtask

  task automatic t_pulses;
    int c[4] = '{IN_HALF_STITCH, IN_ONE_STITCH, IN_RAISE, IN_REV_LIFT};
    int x[4] = '{0, 5, 13, 14};
    int n;
    for (int k = 0; k < 4; k++) begin
      cfg(8'h04, c[k]);
      ndown <= 1'b0;
      press(1, x[k], n);
      chk("pulses needle up", (k < 2) ? 1 : 0, n);
      ndown <= 1'b1;
      press(1, x[k], n);
      chk("pulses needle down", 1, n);
    end
    cfg(8'h04, 32'h0);
    $display("pulse test done");
  endtask

  task automatic t_toggles;
    int c[4] = '{IN_SE_CANCEL, IN_AUTOLIFT, IN_AUTO_REV, IN_ALT_TOGGLE};
    int x[4] = '{6, 7, 17, 18};
    int m[4] = '{OUT_SE_MON, 0, OUT_AUTO_MON, OUT_ALT};
    int n;
    for (int k = 0; k < 4; k++) begin
      cfg(8'h08, c[k]);
      cfg(8'h20, m[k]);
      for (int t = 1; t >= 0; t--) begin
        press(2, x[k], n);
        chk("toggle state", t, co[x[k]]);
        chk("toggle monitor", (m[k] != 0) ? t : 0, oo[0]);
      end
    end
    cfg(8'h08, 32'h0);
    cfg(8'h20, 32'h0);
    $display("toggle test done");
  endtask

  task automatic t_once;
    int n;
    cfg(8'h10, IN_ONCE_CANCEL);
    cfg(8'h28, OUT_ONCE_MON);
    press(4, 2, n);
    chk("once armed", 1, co[2]);
    chk("once monitor", 1, oo[2]);
    bpp <= 1'b1;
    cyc(1);
    bpp <= 1'b0;
    cyc(4);
    chk("once consumed", 0, {oo[2], co[2]});
    $display("once test done");
  endtask

  task automatic t_outputs;
    sol <= 5'h1F;
    cyc(4);
    chk("magnets", 32'h1F, mag);
    for (int oc = 1; oc <= 5; oc++) begin
      cfg(8'h24, oc);
      cyc(4);
      chk("solenoid port", 1, oo[1]);
      chk("magnets", 5'h1F & ~(5'h01 << (oc - 1)), mag);
    end
    cfg(8'h24, OUT_STOPPED);
    stopped <= 1'b1;
    cyc(4);
    chk("stopped on", 1, oo[1]);
    stopped <= 1'b0;
    cyc(4);
    chk("stopped off", 0, oo[1]);
    cfg(8'h24, 32'h0);
    cfg(8'h0C, IN_TRIM_INH);
    closed[3] <= 1'b1;
    cyc(8);
    chk("trim inhibited", 32'h1E, mag);
    closed[3] <= 1'b0;
    $display("output test done");
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(50000 * 20);
    error_cnt++;
    final_report;
  end

  initial begin
    rst = 1'b1; awv = 1'b0; wv = 1'b0; arv = 1'b0; bry = 1'b1; rry = 1'b1;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'h0; closed = 8'h00; sol = 5'h00;
    stopped = 1'b0; ndown = 1'b0; cdim = 1'b0; bpp = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_levels;
    t_pulses;
    t_toggles;
    t_once;
    t_outputs;
    final_report;
  end
endmodule // oiofm_mapper_bench

// >>> testbench/oiofm_switch_model.sv
// Bank of switches on the optional input pins
`timescale 1ns/1ns
module oiofm_switch_model (
  input wire logic i_clock,
  input wire logic [7:0] i_closed,
  output logic [7:0] o_pin
);
  // Open contact leaves the pull-up high, closed pulls the pin low
  initial o_pin = 8'hFF;
  always @(posedge i_clock) begin
    o_pin <= ~i_closed;
  end
endmodule // oiofm_switch_model
